// ### core/lnp_defs.svh
/*
 * constants of the logic, negate and pause unit: instruction fields,
 * encodings, register-port offsets, field positions and reset values.
 * assumes the including file is compiled after this header only once.
 */
`ifndef LNP_DEFS_SVH
`define LNP_DEFS_SVH

// ****************************************************************
// instruction fields
// ****************************************************************
`define LNP_XLEN          64
`define LNP_OP_MSB        31
`define LNP_OP_LSB        26
`define LNP_OP_INT_GRP    6'h00
`define LNP_OP_FP_GRP     6'h15
`define LNP_OP_UNION_IMM  6'h14
`define LNP_FN_NOR        10'h2D0
`define LNP_FN_OR         10'h290
`define LNP_FP_MINOR      7'h2D
`define LNP_FP_MINOR_GRP  6'h3B
`define LNP_FMT_SINGLE    2'h0
`define LNP_FMT_DOUBLE    2'h1
`define LNP_FMT_PAIRED    2'h2
`define LNP_IDLE_WORD     32'h0000_0000
`define LNP_PAUSE_WORD    32'h0000_2800

// ****************************************************************
// register port offsets and fields
// ****************************************************************
`define LNP_ADDR_CTRL     8'h00
`define LNP_ADDR_STATUS   8'h04
`define LNP_ADDR_RETIRED  8'h08
`define LNP_CTRL_FP_IEEE2008_CAPABLE  0
`define LNP_CTRL_NONARITH 1
`define LNP_CTRL_FPU_EN   2
`define LNP_CTRL_MT       3
`define LNP_ST_LINK       0
`define LNP_ST_PAUSED     1
`define LNP_ST_INVALID    8
`define LNP_ST_RESV       9
`define LNP_ST_CPU        10

// ****************************************************************
// reset values
// ****************************************************************
`define LNP_RST_NONARITH  1'b0
`define LNP_RST_FPU_EN    1'b1
`define LNP_RST_MT        1'b0

`endif

// ### core/lnp_pkg.sv
/*
 * types of the logic, negate and pause unit.
 * assumes lnp_defs.svh is on the include path.
 */
`include "lnp_defs.svh"

package lnp_pkg;

    // ****************************************************************
    // operation held in the execute stage
    // ****************************************************************
    typedef enum logic [2:0] {
        OP_NONE  = 3'b000,
        OP_IDLE  = 3'b001,
        OP_NOR   = 3'b010,
        OP_OR    = 3'b011,
        OP_ORI   = 3'b100,
        OP_NEG   = 3'b101
    } lnp_op_type;

endpackage

// ### core/lnp_regfile.sv
/*
 * register file with one write port and two registered read ports.
 * assumes one clock; a read of the entry written in the same cycle
 * returns the new value.
 */
`timescale 1ns/10ps
`default_nettype none

module lnp_regfile #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    // clock
    input  wire logic             clk,
    // write port
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // read ports
    input  wire logic [AW-1:0]    rd_addr_a,
    input  wire logic [AW-1:0]    rd_addr_b,
    output var  logic [WIDTH-1:0] rd_data_a,
    output var  logic [WIDTH-1:0] rd_data_b
);

    if (DEPTH > (1 << AW)) begin : g_check
        $error("lnp_regfile depth exceeds its address range");
    end

    // entries power up at zero so a read before any write is defined
    logic [WIDTH-1:0] mem [DEPTH] = '{default: '0};

    // write-first bypass lets back to back dependent ops run unstalled
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_a <= (wr_en && wr_addr == rd_addr_a) ? wr_data
                                                      : mem[rd_addr_a];
        rd_data_b <= (wr_en && wr_addr == rd_addr_b) ? wr_data
                                                      : mem[rd_addr_b];
    end

endmodule

`default_nettype wire

// ### core/lnp_unit.sv
/*
 * logic, negate and pause unit: decodes and executes idle, not-or, or,
 * or-immediate, sign flip and pause, holds the link reservation flag.
 * assumes an issue stage honouring instr_ready and events from the
 * load/store logic on the same clock; wake_pin is asynchronous.
 */
`timescale 1ns/10ps
`default_nettype none
`include "lnp_defs.svh"

// Contract
// - sign flip inverts only the sign bit
// - arithmetic mode flags NaN as invalid
// - non-arithmetic mode flips sign, never flags
// - decode sign flip by group and minor code
// - paired format is refused as reserved
// - only unusable, reserved, invalid may be reported
// - idle word is shift of zero, no change
// - not-or writes inverted or of sources
// - or writes or of two sources
// - or-immediate zero-extends sixteen bit immediate
// - pause stalls issue until flag clears
// - single thread also resumes on external event
// - multi thread resumes only on flag clear
// - remote store to lock clears flag
// - unimplemented pause decodes as idle
// - load-linked sets the reservation flag
module lnp_unit #(
    parameter int       XLEN       = 64,
    parameter int       NREGS      = 32,
    parameter bit       HAS_2008   = 1'b1,
    parameter bit       PAUSE_IMPL = 1'b1
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // instruction stream
    input  wire logic        instr_valid,
    input  wire logic [31:0] instr_word,
    output var  logic        instr_ready,
    // reservation events
    input  wire logic        ll_event,
    input  wire logic        remote_store_hit,
    input  wire logic        wake_pin,
    // results
    output var  logic        retire,
    output var  logic        wb_valid,
    output var  logic        wb_fp,
    output var  logic [4:0]  wb_addr,
    output var  logic [63:0] wb_data,
    output var  logic        exc_resv,
    output var  logic        exc_cpu,
    output var  logic        fp_invalid,
    output var  logic        paused,
    output var  logic        link_reservation_flag,
    // register port
    input  wire logic [7:0]  bus_addr,
    input  wire logic [31:0] bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    output var  logic [31:0] bus_rdata
);

    // ****************************************************************
    // parameter checks
    // ****************************************************************
    if (XLEN != `LNP_XLEN || NREGS != 32) begin : g_check
        $error("lnp_unit serves only 64-bit data and 32 registers");
    end

    typedef struct packed {
        logic                ready;
        logic                paused;
        logic                link;
        logic [2:0]          wake_sync;
        logic                wake;
        logic                nonarith;
        logic                fpu_en;
        logic                mt;
        logic                st_invalid;
        logic                st_resv;
        logic                st_cpu;
        logic [31:0]         retired;
        logic [31:0]         rdata;
        logic                ex_valid;
        lnp_pkg::lnp_op_type ex_op;
        logic [4:0]          ex_dst;
        logic [15:0]         ex_imm;
        logic                ex_dbl;
        logic                ex_a_zero;
        logic                ex_b_zero;
        logic                ex_resv;
        logic                ex_cpu;
        logic                retire;
        logic                wb_valid;
        logic                wb_fp;
        logic [4:0]          wb_addr;
        logic [63:0]         wb_data;
        logic                exc_resv;
        logic                exc_cpu;
        logic                fp_invalid;
    } lnp_state_type;

    lnp_state_type q;
    lnp_state_type d;

    // ****************************************************************
    // register files
    // ****************************************************************
    logic        gpr_wr_en;
    logic        fpr_wr_en;
    logic [63:0] gpr_a;
    logic [63:0] gpr_b;
    logic [63:0] fpr_a;
    logic [63:0] op_a;
    logic [63:0] op_b;
    logic [63:0] result;
    logic [63:0] flip_mask;
    logic        is_nan;
    logic        arith;

    lnp_regfile #(.WIDTH(64), .DEPTH(32), .AW(5)) u_gpr (
        .clk       (clk),
        .wr_en     (gpr_wr_en),
        .wr_addr   (q.ex_dst),
        .wr_data   (result),
        .rd_addr_a (instr_word[20:16]),
        .rd_addr_b (instr_word[25:21]),
        .rd_data_a (gpr_a),
        .rd_data_b (gpr_b)
    );

    lnp_regfile #(.WIDTH(64), .DEPTH(32), .AW(5)) u_fpr (
        .clk       (clk),
        .wr_en     (fpr_wr_en),
        .wr_addr   (q.ex_dst),
        .wr_data   (result),
        .rd_addr_a (instr_word[20:16]),
        .rd_addr_b (5'h00),
        .rd_data_a (fpr_a),
        .rd_data_b ()
    );

    // ****************************************************************
    // decode
    // ****************************************************************
    logic       take;
    logic [5:0] op6;
    logic       is_idle;
    logic       is_pause;
    logic       is_int;
    logic       is_nor;
    logic       is_or;
    logic       is_ori;
    logic       is_neg;
    logic       fp_sign_flip_ok;

    assign take     = instr_valid && q.ready;
    assign op6      = instr_word[`LNP_OP_MSB:`LNP_OP_LSB];
    assign is_idle  = instr_word == `LNP_IDLE_WORD;
    assign is_pause = instr_word == `LNP_PAUSE_WORD;
    assign is_int   = op6 == `LNP_OP_INT_GRP && !instr_word[10];
    assign is_nor   = is_int && instr_word[9:0] == `LNP_FN_NOR;
    assign is_or    = is_int && instr_word[9:0] == `LNP_FN_OR;
    assign is_ori   = op6 == `LNP_OP_UNION_IMM;
    assign is_neg   = op6 == `LNP_OP_FP_GRP && !instr_word[15]
                   && instr_word[12:6] == `LNP_FP_MINOR
                   && instr_word[5:0] == `LNP_FP_MINOR_GRP;
    assign fp_sign_flip_ok = instr_word[14:13] == `LNP_FMT_SINGLE
                     || instr_word[14:13] == `LNP_FMT_DOUBLE;

    // ****************************************************************
    // execute
    // ****************************************************************
    // register zero reads zero
    assign op_a = q.ex_a_zero ? 64'h0 : gpr_a;
    assign op_b = q.ex_b_zero ? 64'h0 : gpr_b;
    assign flip_mask = q.ex_dbl ? 64'h8000_0000_0000_0000
                                : 64'h0000_0000_8000_0000;
    assign is_nan = q.ex_dbl
        ? (fpr_a[62:52] == 11'h7FF && fpr_a[51:0] != 52'h0)
        : (fpr_a[30:23] == 8'hFF && fpr_a[22:0] != 23'h0);
    assign arith = !HAS_2008 || !q.nonarith;

    always_comb begin
        result = 64'h0;
        unique case (q.ex_op)
            lnp_pkg::OP_NOR: result = ~(op_a | op_b);
            lnp_pkg::OP_OR:  result = op_a | op_b;
            lnp_pkg::OP_ORI: result = op_a | {48'h0, q.ex_imm};
            lnp_pkg::OP_NEG: result = fpr_a ^ flip_mask;
            lnp_pkg::OP_IDLE: result = 64'h0;
            lnp_pkg::OP_NONE: result = 64'h0;
        endcase
    end

    logic ex_ok;
    assign ex_ok = q.ex_valid && !q.ex_resv && !q.ex_cpu;
    assign gpr_wr_en = ex_ok && q.ex_dst != 5'h00
        && (q.ex_op == lnp_pkg::OP_NOR || q.ex_op == lnp_pkg::OP_OR
            || q.ex_op == lnp_pkg::OP_ORI);
    assign fpr_wr_en = ex_ok && q.ex_op == lnp_pkg::OP_NEG;

    // ****************************************************************
    // next state
    // ****************************************************************
    logic resume;
    // multi thread waits for the flag only
    assign resume = q.paused && (!q.link || (!q.mt && q.wake));

    always_comb begin
        d = q;
        // pin synchroniser: a change counts once stages two and three agree
        d.wake_sync = {q.wake_sync[1:0], wake_pin};
        if (q.wake_sync[2] == q.wake_sync[1]) begin
            d.wake = q.wake_sync[2];
        end
        if (remote_store_hit) begin
            d.link = 1'b0;
        end
        // load-linked sets flag, wins over clear
        if (ll_event) begin
            d.link = 1'b1;
        end

        d.ex_valid  = take;
        d.ex_op     = lnp_pkg::OP_NONE;
        d.ex_dst    = instr_word[25:21];
        d.ex_imm    = instr_word[15:0];
        d.ex_dbl    = instr_word[13];
        d.ex_a_zero = instr_word[20:16] == 5'h00;
        d.ex_b_zero = instr_word[25:21] == 5'h00;
        d.ex_resv   = 1'b0;
        d.ex_cpu    = 1'b0;
        if (take) begin
            if (is_idle) begin
                d.ex_op = lnp_pkg::OP_IDLE;
            end else if (is_pause) begin
                d.ex_op = lnp_pkg::OP_IDLE;
                if (PAUSE_IMPL && q.link) begin
                    d.ex_valid = 1'b0;
                    d.paused   = 1'b1;
                    d.ready    = 1'b0;
                end
            end else if (is_nor) begin
                d.ex_op  = lnp_pkg::OP_NOR;
                d.ex_dst = instr_word[15:11];
            end else if (is_or) begin
                d.ex_op  = lnp_pkg::OP_OR;
                d.ex_dst = instr_word[15:11];
            end else if (is_ori) begin
                d.ex_op  = lnp_pkg::OP_ORI;
            end else if (is_neg) begin
                d.ex_op   = lnp_pkg::OP_NEG;
                d.ex_cpu  = !q.fpu_en;
                d.ex_resv = q.fpu_en && !fp_sign_flip_ok;
            end else begin
                d.ex_resv = 1'b1;
            end
        end
        if (resume) begin
            d.paused = 1'b0;
            d.ready  = 1'b1;
        end

        d.retire     = (ex_ok && q.ex_op != lnp_pkg::OP_NONE) || resume;
        d.wb_valid   = gpr_wr_en || fpr_wr_en;
        d.wb_fp      = fpr_wr_en;
        d.wb_addr    = q.ex_dst;
        d.wb_data    = result;
        d.exc_resv   = q.ex_valid && q.ex_resv;
        d.exc_cpu    = q.ex_valid && q.ex_cpu;
        // NaN signals invalid in arithmetic mode
        d.fp_invalid = fpr_wr_en && arith && is_nan;
        if (d.retire) begin
            d.retired = q.retired + 32'h1;
        end

        d.rdata = 32'h0;
        if (bus_rd) begin
            unique case (bus_addr)
                `LNP_ADDR_CTRL: begin
                    d.rdata[`LNP_CTRL_FP_IEEE2008_CAPABLE]  = HAS_2008;
                    d.rdata[`LNP_CTRL_NONARITH] = q.nonarith;
                    d.rdata[`LNP_CTRL_FPU_EN]   = q.fpu_en;
                    d.rdata[`LNP_CTRL_MT]       = q.mt;
                end
                `LNP_ADDR_STATUS: begin
                    d.rdata[`LNP_ST_LINK]    = q.link;
                    d.rdata[`LNP_ST_PAUSED]  = q.paused;
                    d.rdata[`LNP_ST_INVALID] = q.st_invalid;
                    d.rdata[`LNP_ST_RESV]    = q.st_resv;
                    d.rdata[`LNP_ST_CPU]     = q.st_cpu;
                end
                `LNP_ADDR_RETIRED: d.rdata = q.retired;
                default: d.rdata = 32'h0;
            endcase
        end
        if (bus_wr && bus_addr == `LNP_ADDR_CTRL) begin
            d.nonarith = bus_wdata[`LNP_CTRL_NONARITH];
            d.fpu_en   = bus_wdata[`LNP_CTRL_FPU_EN];
            d.mt       = bus_wdata[`LNP_CTRL_MT];
        end
        if (bus_wr && bus_addr == `LNP_ADDR_STATUS) begin
            d.st_invalid = q.st_invalid && !bus_wdata[`LNP_ST_INVALID];
            d.st_resv    = q.st_resv && !bus_wdata[`LNP_ST_RESV];
            d.st_cpu     = q.st_cpu && !bus_wdata[`LNP_ST_CPU];
        end
        // sticky sets come last so a same-cycle clear cannot lose one
        d.st_invalid = d.st_invalid || d.fp_invalid;
        d.st_resv    = d.st_resv || d.exc_resv;
        d.st_cpu     = d.st_cpu || d.exc_cpu;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            q          <= '0;
            q.ready    <= 1'b1;
            q.nonarith <= `LNP_RST_NONARITH;
            q.fpu_en   <= `LNP_RST_FPU_EN;
            q.mt       <= `LNP_RST_MT;
        end else begin
            q <= d;
        end
    end

    assign instr_ready           = q.ready;
    assign retire                = q.retire;
    assign wb_valid              = q.wb_valid;
    assign wb_fp                 = q.wb_fp;
    assign wb_addr               = q.wb_addr;
    assign wb_data               = q.wb_data;
    assign exc_resv              = q.exc_resv;
    assign exc_cpu               = q.exc_cpu;
    assign fp_invalid            = q.fp_invalid;
    assign paused                = q.paused;
    assign link_reservation_flag = q.link;
    assign bus_rdata             = q.rdata;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_take_neg;
        take && is_neg && q.fpu_en;
    endsequence

    property p_neg_value;
        fpr_wr_en |=> wb_valid && wb_fp
            && wb_data == ($past(fpr_a) ^ $past(flip_mask));
    endproperty
    a_neg_value: assert property (p_neg_value)
        else $error("sign flip result wrong");

    property p_nan_invalid;
        fpr_wr_en && is_nan && arith |=> fp_invalid;
    endproperty
    a_nan_invalid: assert property (p_nan_invalid)
        else $error("NaN did not raise invalid");

    property p_nonarith_quiet;
        ex_ok && !arith |=> !fp_invalid;
    endproperty
    a_nonarith_quiet: assert property (p_nonarith_quiet)
        else $error("non-arithmetic flip raised invalid");

    property p_neg_decode;
        s_take_neg ##0 fp_sign_flip_ok |=> fpr_wr_en ##1 wb_fp && retire;
    endproperty
    a_neg_decode: assert property (p_neg_decode)
        else $error("sign flip not decoded");

    property p_paired_refused;
        s_take_neg ##0 !fp_sign_flip_ok |=> !fpr_wr_en ##1 exc_resv && !retire;
    endproperty
    a_paired_refused: assert property (p_paired_refused)
        else $error("paired format not refused");

    property p_idle_quiet;
        take && is_idle |=> !gpr_wr_en && !fpr_wr_en ##1 retire && !wb_valid;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("idle word changed state");

    property p_nor_value;
        gpr_wr_en && q.ex_op == lnp_pkg::OP_NOR
            |=> wb_data == ~($past(op_a) | $past(op_b));
    endproperty
    a_nor_value: assert property (p_nor_value)
        else $error("not-or result wrong");

    property p_or_value;
        gpr_wr_en && q.ex_op == lnp_pkg::OP_OR
            |=> wb_data == ($past(op_a) | $past(op_b));
    endproperty
    a_or_value: assert property (p_or_value)
        else $error("or result wrong");

    property p_ori_value;
        gpr_wr_en && q.ex_op == lnp_pkg::OP_ORI
            |=> wb_data[63:16] == $past(op_a[63:16]);
    endproperty
    a_ori_value: assert property (p_ori_value)
        else $error("immediate not zero-extended");

    property p_pause_stall;
        take && is_pause && q.link && PAUSE_IMPL
            |=> !instr_ready && paused;
    endproperty
    a_pause_stall: assert property (p_pause_stall)
        else $error("pause did not stall issue");

    property p_resume;
        paused && !link_reservation_flag |=> instr_ready && retire;
    endproperty
    a_resume: assert property (p_resume)
        else $error("pause did not resume on clear flag");

    property p_store_clears;
        remote_store_hit && !ll_event |=> !link_reservation_flag;
    endproperty
    a_store_clears: assert property (p_store_clears)
        else $error("remote store left flag set");

    property p_ll_sets;
        ll_event |=> link_reservation_flag;
    endproperty
    a_ll_sets: assert property (p_ll_sets)
        else $error("load-linked did not set flag");

    property p_pause_free;
        take && is_pause && !q.link |=> instr_ready ##1 retire;
    endproperty
    a_pause_free: assert property (p_pause_free)
        else $error("pause stalled with flag clear");

endmodule

`default_nettype wire

// ### verif/lnp_issue_model.sv
/* issue side model: offers one word per request, holds it until taken.
   assumes one clock shared with the unit and its ready signal. */
`timescale 1ns/10ps
`default_nettype none
`include "lnp_defs.svh"
module lnp_issue_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // bench request
    input  wire logic        req,
    input  wire logic [31:0] req_word,
    // issue port
    input  wire logic        instr_ready,
    output var  logic        instr_valid,
    output var  logic [31:0] instr_word
);
    // idle padding word
    // a released word is inverted so a stale copy never looks current
    always_ff @(posedge clk) begin
        if (reset) begin
            instr_valid <= 1'b0;
            instr_word  <= `LNP_IDLE_WORD;
        end else if (req) begin
            instr_valid <= 1'b1;
            instr_word  <= req_word;
        end else if (instr_valid && instr_ready) begin
            instr_valid <= 1'b0;
            instr_word  <= ~instr_word;
        end
    end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
/* bench for the logic, negate and pause unit.
   assumes the core files and the issue model are compiled first. */
`timescale 1ns/10ps
`default_nettype none
`include "lnp_defs.svh"
module tb_top;
    logic        clk, reset, req, instr_valid, instr_ready, ll_event;
    logic        remote_store_hit, wake_pin, retire, wb_valid, wb_fp;
    logic        exc_resv, exc_cpu, fp_invalid, paused;
    logic        link_reservation_flag, bus_wr, bus_rd;
    logic [4:0]  wb_addr;
    logic [7:0]  bus_addr;
    logic [31:0] req_word, instr_word, bus_wdata, bus_rdata;
    logic [63:0] wb_data;
    int          num_errors = 0;
    int          cmp_count = 0;

    lnp_issue_model src (.clk, .reset, .req, .req_word, .instr_ready,
                         .instr_valid, .instr_word);
    lnp_unit dut (.clk, .reset, .instr_valid, .instr_word, .instr_ready,
        .ll_event, .remote_store_hit, .wake_pin, .retire, .wb_valid,
        .wb_fp, .wb_addr, .wb_data, .exc_resv, .exc_cpu, .fp_invalid,
        .paused, .link_reservation_flag, .bus_addr, .bus_wdata, .bus_wr,
        .bus_rd, .bus_rdata);

    task automatic chk(input string n, input logic [63:0] e, g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic end_sim;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge clk);
        bus_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge clk);
        bus_rd   <= 1'b0;
        #1 chk("rdata", 64'(e), 64'(bus_rdata));
        @(posedge clk);
    endtask
    // f is {retire, wb_valid, wb_fp, exc_resv, exc_cpu} two edges on
    task automatic run(input logic [31:0] w, input logic [4:0] f,
                       input logic [4:0] a, input logic [63:0] d);
        req      <= 1'b1;
        req_word <= w;
        @(posedge clk);
        req <= 1'b0;
        do
            @(posedge clk);
        while (!(instr_valid === 1'b1 && instr_ready === 1'b1));
        // results stand in the second cycle after the take edge
        @(posedge clk);
        #1 chk("flags", 64'(f),
               64'({retire, wb_valid, wb_fp, exc_resv, exc_cpu}));
        chk("fp_invalid", 64'h0, 64'(fp_invalid));
        if (f[3]) begin
            chk("wb_addr", 64'(a), 64'(wb_addr));
            chk("wb_data", d, wb_data);
        end
    endtask
    task automatic hold;
        ll_event <= 1'b1;
        @(posedge clk);
        ll_event <= 1'b0;
        #1 chk("flag", 64'h1, 64'(link_reservation_flag));
        run(`LNP_PAUSE_WORD, 5'h00, 5'd0, 64'h0);
        chk("stall", 64'h2, 64'({paused, instr_ready}));
    endtask
    task automatic lock_free;
        remote_store_hit <= 1'b1;
        @(posedge clk);
        remote_store_hit <= 1'b0;
        #1 chk("flag", 64'h0, 64'(link_reservation_flag));
        @(posedge clk);
        #1 chk("resume", 64'h5, 64'({retire, paused, instr_ready}));
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // about 120 cycles of tests; a hang is cut well after that
    initial begin
        #100000;
        num_errors++;
        end_sim();
    end
    initial begin
        reset = 1'b1;
        {req, req_word, ll_event, remote_store_hit, wake_pin} = '0;
        {bus_addr, bus_wdata, bus_wr, bus_rd} = '0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rd(`LNP_ADDR_CTRL, 32'h5);
        rd(`LNP_ADDR_STATUS, 32'h0);
        rd(8'h0C, 32'h0);
        run({6'h14, 5'd1, 5'd0, 16'h8001}, 5'h18, 5'd1, 64'h8001);
        run({6'h14, 5'd2, 5'd0, 16'h4300}, 5'h18, 5'd2, 64'h4300);
        run({11'h2, 5'd1, 5'd3, 11'h290}, 5'h18, 5'd3, 64'hC301);
        run({11'h2, 5'd1, 5'd4, 11'h2D0}, 5'h18, 5'd4,
            64'hFFFF_FFFF_FFFF_3CFE);
        run({6'h14, 5'd0, 5'd1, 16'h00FF}, 5'h10, 5'd0, 64'h0);
        run({16'h0, 5'd5, 11'h290}, 5'h18, 5'd5, 64'h0);
        run(`LNP_IDLE_WORD, 5'h10, 5'd0, 64'h0);
        run(32'hFFFF_FFFF, 5'h02, 5'd0, 64'h0);
        for (int i = 0; i < 4; i++) begin
            run({6'h15, 5'd7, 5'd3, 1'b0, 2'(i), 7'h2D, 6'h3B},
                i < 2 ? 5'h1C : 5'h02, 5'd7,
                i == 0 ? 64'h8000_0000 : {i == 1, 63'h0});
        end
        wr(`LNP_ADDR_CTRL, 32'h0);
        run({6'h15, 5'd7, 5'd3, 3'h0, 7'h2D, 6'h3B}, 5'h01, 5'd7,
            64'h0);
        rd(`LNP_ADDR_STATUS, 32'h600);
        wr(`LNP_ADDR_STATUS, 32'h700);
        rd(`LNP_ADDR_STATUS, 32'h0);
        // non-arithmetic mode: flip f7 back to zero into f6
        wr(`LNP_ADDR_CTRL, 32'h6);
        rd(`LNP_ADDR_CTRL, 32'h7);
        run({6'h15, 5'd6, 5'd7, 3'h1, 7'h2D, 6'h3B}, 5'h1C, 5'd6,
            64'h0);
        wr(`LNP_ADDR_CTRL, 32'h4);
        run(`LNP_PAUSE_WORD, 5'h10, 5'd0, 64'h0);
        chk("ready", 64'h1, 64'(instr_ready));
        hold();
        lock_free();
        hold();
        wake_pin <= 1'b1;
        for (int i = 0; i < 8 && retire !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk("wake", 64'h1, 64'(retire));
        wake_pin <= 1'b0;
        repeat (6) @(posedge clk);
        wr(`LNP_ADDR_CTRL, 32'hC);
        hold();
        wake_pin <= 1'b1;
        repeat (8) @(posedge clk);
        #1 chk("stall", 64'h2, 64'({paused, instr_ready}));
        lock_free();
        wake_pin <= 1'b0;
        rd(`LNP_ADDR_RETIRED, 32'h0000_000E);
        end_sim();
    end
endmodule
`default_nettype wire
